/* File: ptt_pkg.sv */
// shared constants and types for the target termination block
package ptt_pkg;

    // ------------------------------------------------------------
    // timing limits, in clock cycles of the bus clock
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8; // bus clock period
    localparam int unsigned FIRST_LIMIT_CLKS = 16; // first data phase limit
    localparam int unsigned NEXT_LIMIT_CLKS = 8; // later data phase limit
    localparam int unsigned CNT_W = 5; // latency counter width
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00; // counter clear value
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01; // counter step
    localparam logic [CNT_W-1:0] FIRST_LIMIT = CNT_W'(FIRST_LIMIT_CLKS);
    localparam logic [CNT_W-1:0] NEXT_LIMIT = CNT_W'(NEXT_LIMIT_CLKS);

    // ------------------------------------------------------------
    // data widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32; // bus word width
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000; // data reset value

    // ------------------------------------------------------------
    // termination kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PTT_TERM_NONE,
        PTT_TERM_WITH_DATA,
        PTT_TERM_WITHOUT_DATA,
        PTT_TERM_RETRY,
        PTT_TERM_ABORT
    } ptt_term_t;

    // decode of the three back-end request levels (active low)
    function automatic ptt_term_t term_decode(input logic rdy_n, input logic disc_n,
                                              input logic abort_n, input logic first);
        ptt_term_t t;
        t = PTT_TERM_NONE;
        if (!abort_n) begin
            t = PTT_TERM_ABORT;
        end else if (!disc_n && !rdy_n) begin
            t = PTT_TERM_WITH_DATA;
        end else if (!disc_n) begin
            t = first ? PTT_TERM_RETRY : PTT_TERM_WITHOUT_DATA;
        end
        return t;
    endfunction

endpackage

/* File: ptt_bus_if.sv */
// interface joining the bus-master end and the target end
`timescale 1ns/10ps
interface ptt_bus_if;
    // master driven; framen and irdyn active low, write high for a write
    logic framen;
    logic irdyn;
    logic write;
    // target driven pins: output and enable (enable low means driving)
    logic devseln_o;
    logic devseln_oe_n;
    logic trdyn_o;
    logic trdyn_oe_n;
    logic stopn_o;
    logic stopn_oe_n;
    // shared address/data wires
    logic [31:0] ad_mst_o;
    logic ad_mst_oe_n;
    logic [31:0] ad_tgt_o;
    logic ad_tgt_oe_n;
    // resolved levels (released control pins pulled high, released ad reads zero)
    logic devseln;
    logic trdyn;
    logic stopn;
    logic [31:0] ad;

    // ------------------------------------------------------------
    // wire resolution from the enables
    // ------------------------------------------------------------
    assign devseln = devseln_oe_n ? 1'b1 : devseln_o;
    assign trdyn = trdyn_oe_n ? 1'b1 : trdyn_o;
    assign stopn = stopn_oe_n ? 1'b1 : stopn_o;
    assign ad = !ad_tgt_oe_n ? ad_tgt_o : (!ad_mst_oe_n ? ad_mst_o : 32'h0000_0000);

    modport target (
        input framen, irdyn, write, ad,
        output devseln_o, devseln_oe_n, trdyn_o, trdyn_oe_n, stopn_o, stopn_oe_n,
        output ad_tgt_o, ad_tgt_oe_n
    );
    modport master (
        input devseln, trdyn, stopn, ad,
        output framen, irdyn, write, ad_mst_o, ad_mst_oe_n
    );
endinterface

/* File: ptt_lat_timer.sv */
// latency watchdog counting clocks of one data phase
`timescale 1ns/10ps
module ptt_lat_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic run,
    input wire logic [4:0] limit,
    output logic expired
);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [4:0] cnt_reg; // clocks elapsed
    logic [4:0] cnt_next;

    // next count: restart or count up to the limit
    always_comb begin
        cnt_next = cnt_reg;
        if (clear) begin
            cnt_next = ptt_pkg::CNT_ZERO;
        end else if (run && cnt_reg != limit) begin
            cnt_next = cnt_reg + ptt_pkg::CNT_ONE;
        end
    end

    // register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= ptt_pkg::CNT_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired = run && (cnt_reg == limit);

endmodule

/* File: ptt_target.sv */
// target end: turns back-end requests into bus termination sequences
`timescale 1ns/10ps
module ptt_target (
    input wire logic clk,
    input wire logic rstn,
    ptt_bus_if.target bus,
    input wire logic backend_ready_n,
    input wire logic backend_disconnect_req_n,
    input wire logic backend_abort_req_n,
    input wire logic [31:0] local_read_data_in,
    output logic local_xfer_strobe_n,
    output logic [31:0] local_write_data_out,
    output logic target_abort_flag
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, // waiting for frame
        ST_ACTIVE, // selected, data phases running
        ST_STOP, // stop driven, wait for frame high
        ST_DROP, // devsel and stop deasserted
        ST_RELEASE // pins released, one quiet clock
    } ptt_state_t;

    ptt_state_t state_reg, state_next;
    logic rdy_reg, rdy_next; // ready seen last clock (active high)
    logic disc_reg, disc_next; // disconnect seen last clock
    logic rdy_eff; // ready as it steers this clock
    logic disc_eff; // disconnect as it steers this clock
    logic first_reg, first_next; // still in first data phase
    logic moved_reg, moved_next; // one word already transferred
    logic write_reg, write_next; // transaction is a write
    logic trdy_reg, trdy_next; // trdy asserted (high = asserted)
    logic stop_reg, stop_next; // stop asserted
    logic devsel_reg, devsel_next; // devsel asserted
    logic drive_reg, drive_next; // target drives control pins
    logic xfer_reg, xfer_next; // local read strobe asserted
    logic abort_reg, abort_next; // abort ended this transaction
    logic [31:0] rdata_reg, rdata_next; // read word to bus
    logic [31:0] wdata_reg, wdata_next; // write word to back-end
    logic adoe_reg, adoe_next; // drives ad on reads
    logic lim_clear; // restart watchdog
    logic lim_expired; // phase limit hit
    logic [4:0] lim_value; // current phase limit
    logic frame_start; // frame asserted from idle
    logic phase_done; // data phase completes this clock
    ptt_pkg::ptt_term_t term; // decoded request this clock

    // ------------------------------------------------------------
    // watchdog: 16 clocks first phase, eight after
    // ------------------------------------------------------------
    // first phase lasts until a word has moved
    assign lim_value = moved_reg ? ptt_pkg::NEXT_LIMIT : ptt_pkg::FIRST_LIMIT;
    assign lim_clear = frame_start || phase_done;

    ptt_lat_timer ptt_lat_timer_i (
        .clk(clk),
        .rstn(rstn),
        .clear(lim_clear),
        .run(state_reg == ST_ACTIVE),
        .limit(lim_value),
        .expired(lim_expired)
    );

    assign frame_start = (state_reg == ST_IDLE) && !bus.framen;
    assign phase_done = trdy_reg && !bus.irdyn && (state_reg != ST_IDLE);
    // requests sampled on every edge
    assign term = ptt_pkg::term_decode(backend_ready_n, backend_disconnect_req_n,
                                       backend_abort_req_n, first_reg);
    // writes answer one clock after the request, reads one clock later
    assign rdy_eff = write_reg ? !backend_ready_n : rdy_reg;
    assign disc_eff = write_reg ? !backend_disconnect_req_n : disc_reg;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        rdy_next = !backend_ready_n;
        disc_next = !backend_disconnect_req_n;
        first_next = first_reg;
        moved_next = moved_reg;
        write_next = write_reg;
        trdy_next = trdy_reg;
        stop_next = stop_reg;
        devsel_next = devsel_reg;
        drive_next = drive_reg;
        xfer_next = !backend_ready_n && state_reg == ST_ACTIVE && !write_reg;
        abort_next = abort_reg;
        rdata_next = rdata_reg;
        wdata_next = wdata_reg;
        adoe_next = adoe_reg;
        if (phase_done) begin
            moved_next = 1'b1;
            first_next = 1'b0;
            if (write_reg) begin
                wdata_next = bus.ad;
            end
        end
        if (xfer_reg) begin
            rdata_next = local_read_data_in;
        end
        unique case (state_reg)
            ST_IDLE: begin
                trdy_next = 1'b0;
                stop_next = 1'b0;
                if (!bus.framen) begin
                    state_next = ST_ACTIVE;
                    devsel_next = 1'b1;
                    drive_next = 1'b1;
                    first_next = 1'b1;
                    moved_next = 1'b0;
                    abort_next = 1'b0;
                    write_next = bus.write;
                    adoe_next = !bus.write;
                end
            end
            ST_ACTIVE: begin
                // trdy: read two clocks after ready, write one clock after
                trdy_next = rdy_eff;
                if (term == ptt_pkg::PTT_TERM_ABORT) begin
                    state_next = ST_STOP;
                    abort_next = 1'b1;
                    devsel_next = 1'b0;
                    stop_next = 1'b1;
                    trdy_next = 1'b0;
                end else if (lim_expired && !rdy_eff) begin
                    // first phase gives Retry, later gives without-data
                    state_next = ST_STOP;
                    stop_next = 1'b1;
                    trdy_next = 1'b0;
                end else if (disc_eff && rdy_eff) begin
                    // with data: stop together with trdy, word moves now
                    state_next = ST_STOP;
                    stop_next = 1'b1;
                end else if (disc_eff && !rdy_eff) begin
                    // disconnect without ready: without data or Retry
                    state_next = ST_STOP;
                    stop_next = 1'b1;
                    trdy_next = 1'b0;
                end
            end
            ST_STOP: begin
                // trdy ends once its phase completed; stop held until frame high
                if (phase_done) begin
                    trdy_next = 1'b0;
                end
                if (bus.framen) begin
                    trdy_next = 1'b0;
                    state_next = ST_DROP;
                    devsel_next = 1'b0;
                    stop_next = 1'b0;
                end
            end
            ST_DROP: begin
                // release the pins one clock after deasserting them
                state_next = ST_RELEASE;
                adoe_next = 1'b0;
                drive_next = 1'b0;
            end
            ST_RELEASE: begin
                // one quiet clock before the next claim
                state_next = ST_IDLE;
            end
        endcase
        // release ad on reads once frame is seen high in ST_STOP
        if (state_reg == ST_STOP && bus.framen) begin
            adoe_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            rdy_reg <= 1'b0;
            disc_reg <= 1'b0;
            first_reg <= 1'b0;
            moved_reg <= 1'b0;
            write_reg <= 1'b0;
            trdy_reg <= 1'b0;
            stop_reg <= 1'b0;
            devsel_reg <= 1'b0;
            drive_reg <= 1'b0;
            xfer_reg <= 1'b0;
            abort_reg <= 1'b0;
            rdata_reg <= ptt_pkg::DATA_ZERO;
            wdata_reg <= ptt_pkg::DATA_ZERO;
            adoe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rdy_reg <= rdy_next;
            disc_reg <= disc_next;
            first_reg <= first_next;
            moved_reg <= moved_next;
            write_reg <= write_next;
            trdy_reg <= trdy_next;
            stop_reg <= stop_next;
            devsel_reg <= devsel_next;
            drive_reg <= drive_next;
            xfer_reg <= xfer_next;
            abort_reg <= abort_next;
            rdata_reg <= rdata_next;
            wdata_reg <= wdata_next;
            adoe_reg <= adoe_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.devseln_o = !devsel_reg;
    assign bus.trdyn_o = !trdy_reg;
    assign bus.stopn_o = !stop_reg;
    assign bus.devseln_oe_n = !drive_reg;
    assign bus.trdyn_oe_n = !drive_reg;
    assign bus.stopn_oe_n = !drive_reg;
    assign bus.ad_tgt_o = rdata_reg;
    assign bus.ad_tgt_oe_n = !(adoe_reg && drive_reg);
    // write strobe in the clock the phase completes, read strobe after ready
    assign local_xfer_strobe_n = write_reg ? !phase_done : !xfer_reg;
    assign local_write_data_out = write_reg ? bus.ad : wdata_reg;
    assign target_abort_flag = abort_reg;

endmodule

/* File: ptt_master.sv */
// bus-master end: runs one transaction and honours target termination
`timescale 1ns/10ps
module ptt_master (
    input wire logic clk,
    input wire logic rstn,
    ptt_bus_if.master bus,
    input wire logic start,
    input wire logic start_write,
    input wire logic [31:0] wdata,
    output logic busy,
    output logic [31:0] rdata,
    output logic word_done
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MS_IDLE, // bus idle
        MS_DATA, // frame and irdy asserted
        MS_LAST, // frame dropped, irdy held
        MS_TURN // irdy dropped
    } ptt_mstate_t;

    ptt_mstate_t st_reg, st_next;
    logic frame_reg, frame_next; // frame asserted
    logic irdy_reg, irdy_next; // irdy asserted
    logic wr_reg, wr_next; // write transaction
    logic [31:0] rdata_reg, rdata_next; // captured read word
    logic done_reg, done_next; // word moved pulse
    logic [31:0] wd_reg, wd_next; // write word

    // next-state: frame drops with stop, irdy one clock later
    always_comb begin
        st_next = st_reg;
        frame_next = frame_reg;
        irdy_next = irdy_reg;
        wr_next = wr_reg;
        rdata_next = rdata_reg;
        wd_next = wd_reg;
        done_next = 1'b0;
        unique case (st_reg)
            MS_IDLE: begin
                if (start) begin
                    st_next = MS_DATA;
                    frame_next = 1'b1;
                    irdy_next = 1'b1;
                    wr_next = start_write;
                    wd_next = wdata;
                end
            end
            MS_DATA: begin
                if (!bus.trdyn) begin
                    done_next = 1'b1;
                    rdata_next = bus.ad;
                end
                if (!bus.stopn) begin
                    st_next = MS_LAST;
                    frame_next = 1'b0;
                end
            end
            MS_LAST: begin
                if (!bus.trdyn) begin
                    done_next = 1'b1;
                    rdata_next = bus.ad;
                end
                st_next = MS_TURN;
                irdy_next = 1'b0;
            end
            MS_TURN: begin
                st_next = MS_IDLE;
            end
        endcase
    end

    // registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= MS_IDLE;
            frame_reg <= 1'b0;
            irdy_reg <= 1'b0;
            wr_reg <= 1'b0;
            rdata_reg <= ptt_pkg::DATA_ZERO;
            wd_reg <= ptt_pkg::DATA_ZERO;
            done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            frame_reg <= frame_next;
            irdy_reg <= irdy_next;
            wr_reg <= wr_next;
            rdata_reg <= rdata_next;
            wd_reg <= wd_next;
            done_reg <= done_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.framen = !frame_reg;
    assign bus.irdyn = !irdy_reg;
    assign bus.write = wr_reg;
    assign bus.ad_mst_o = wd_reg;
    assign bus.ad_mst_oe_n = !(wr_reg && st_reg != MS_IDLE);
    assign busy = st_reg != MS_IDLE;
    assign rdata = rdata_reg;
    assign word_done = done_reg;

endmodule

/* File: ptt_term_monitor.sv */
// bus-side checker for the target termination link
`timescale 1ns/10ps
module ptt_term_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic framen,
    input wire logic irdyn,
    input wire logic write,
    input wire logic devseln,
    input wire logic trdyn,
    input wire logic stopn,
    input wire logic devseln_oe_n,
    input wire logic trdyn_oe_n,
    input wire logic stopn_oe_n,
    input wire logic ad_tgt_oe_n
);
    // ------------------------------------------------------------
    // properties on the resolved pins and the target enables
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // new frame is claimed on the next clock
    property p_claim; $fell(framen) |=> !devseln; endproperty
    // first phase ends in stop when no word comes
    property p_first_limit; $fell(framen) |-> ##[1:18] !stopn; endproperty
    // later phase answers or stops within eleven clocks
    property p_next_limit;
        (!trdyn && !irdyn && stopn) |=> ##[0:10] (!trdyn || !stopn);
    endproperty
    // read data is on the bus whenever trdy is low
    property p_read_drive; (!trdyn && !write) |-> !ad_tgt_oe_n; endproperty
    // trdy only inside a claimed transaction
    property p_trdy_claimed; !trdyn |-> !devseln; endproperty
    // stop stays low while the frame is still up
    property p_stop_hold; (!stopn && !framen) |=> !stopn; endproperty
    // last word with stop drops trdy next clock
    property p_trdy_drop; (!trdyn && !irdyn && !stopn) |=> trdyn; endproperty
    // abort is stop without devsel and without data
    property p_abort_no_data; (!stopn && devseln) |-> trdyn; endproperty
    // devsel is deasserted no later than stop ends
    property p_stop_devsel; $rose(stopn) |-> devseln; endproperty
    // pins released one clock after deassertion
    property p_release;
        $rose(stopn) |=> (devseln_oe_n && stopn_oe_n && trdyn_oe_n);
    endproperty

    a_claim: assert property (p_claim) else $error("frame not claimed");
    a_first_limit: assert property (p_first_limit) else $error("no first phase stop");
    a_next_limit: assert property (p_next_limit) else $error("later phase too slow");
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");
    a_trdy_claimed: assert property (p_trdy_claimed) else $error("trdy without devsel");
    a_stop_hold: assert property (p_stop_hold) else $error("stop dropped early");
    a_trdy_drop: assert property (p_trdy_drop) else $error("trdy held past stop");
    a_abort_no_data: assert property (p_abort_no_data) else $error("abort moved data");
    a_stop_devsel: assert property (p_stop_devsel) else $error("devsel kept after stop");
    a_release: assert property (p_release) else $error("pins not released");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_with_data: cover property (!trdyn && !irdyn && !stopn);
    c_abort: cover property (!stopn && devseln);
    c_no_data: cover property ($fell(stopn) && trdyn && !devseln);
endmodule

/* File: pci_target_termination_test.sv */
// self-checking bench joining master end and target end
`timescale 1ns/10ps
module pci_target_termination_test;
    logic clk, rstn, rdy_n, disc_n, abort_n, start, start_write; // bench-driven
    logic strobe_n, abort_flag, busy, word_done; // design outputs
    logic [31:0] rd_in, wr_out, wdata, rdata; // data paths
    int n_mismatch, n_compared, n_words, n_trdy; // tallies
    ptt_bus_if bus_i ();

    ptt_target ptt_target_i (.clk(clk), .rstn(rstn), .bus(bus_i.target),
        .backend_ready_n(rdy_n), .backend_disconnect_req_n(disc_n),
        .backend_abort_req_n(abort_n), .local_read_data_in(rd_in),
        .local_xfer_strobe_n(strobe_n), .local_write_data_out(wr_out),
        .target_abort_flag(abort_flag));
    ptt_master ptt_master_i (.clk(clk), .rstn(rstn), .bus(bus_i.master), .start(start),
        .start_write(start_write), .wdata(wdata), .busy(busy), .rdata(rdata),
        .word_done(word_done));
    ptt_term_monitor ptt_term_monitor_i (.clk(clk), .rstn(rstn), .framen(bus_i.framen),
        .irdyn(bus_i.irdyn), .write(bus_i.write), .devseln(bus_i.devseln),
        .trdyn(bus_i.trdyn), .stopn(bus_i.stopn), .devseln_oe_n(bus_i.devseln_oe_n),
        .trdyn_oe_n(bus_i.trdyn_oe_n), .stopn_oe_n(bus_i.stopn_oe_n),
        .ad_tgt_oe_n(bus_i.ad_tgt_oe_n));

    // ------------------------------------------------------------
    // clock, tallies and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // count moved words and trdy clocks of the running transaction
    always @(posedge clk) begin
        if (word_done === 1'b1) n_words <= n_words + 1;
        if (bus_i.trdyn === 1'b0) n_trdy <= n_trdy + 1;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // start one transaction, then wait for the claim
    task automatic go(input logic wr, input logic [31:0] d);
        int k;
        @(negedge clk);
        n_words = 0;
        n_trdy = 0;
        start_write = wr;
        wdata = d;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (k = 0; k < 40 && bus_i.devseln !== 1'b0; k++) @(negedge clk);
        check("claim_wait", 32'h0, 32'(k == 40));
    endtask

    // count clocks until stop is seen
    task automatic wait_stop(output int k);
        for (k = 0; k < 60 && bus_i.stopn !== 1'b0; k++) @(negedge clk);
    endtask

    // wait for the bus to go quiet, then idle the back-end
    task automatic wait_idle();
        int k;
        for (k = 0; k < 40 && (busy !== 1'b0 || bus_i.stopn_oe_n !== 1'b1); k++)
            @(negedge clk);
        check("idle_wait", 32'h0, 32'(k == 40));
        rdy_n = 1'b1;
        disc_n = 1'b1;
        abort_n = 1'b1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_read_with_data();
        rd_in = 32'ha5c3_0f01;
        go(1'b0, 32'h0);
        rdy_n = 1'b0;
        disc_n = 1'b0;
        @(negedge clk);
        check("rd_strobe", 1'b0, strobe_n);
        rdy_n = 1'b1;
        @(negedge clk);
        check("rd_strobe_end", 1'b1, strobe_n);
        check("rd_trdy", 1'b0, bus_i.trdyn);
        check("rd_stop", 1'b0, bus_i.stopn);
        check("rd_ad", rd_in, bus_i.ad);
        wait_idle();
        check("rd_word", rd_in, rdata);
        check("rd_count", 32'h1, n_words);
    endtask

    task automatic t_write_with_data();
        go(1'b1, 32'h3c96_e107);
        rdy_n = 1'b0;
        disc_n = 1'b0;
        @(negedge clk);
        check("wr_trdy", 1'b0, bus_i.trdyn);
        check("wr_stop", 1'b0, bus_i.stopn);
        check("wr_strobe", 1'b0, strobe_n);
        check("wr_data", 32'h3c96_e107, wr_out);
        rdy_n = 1'b1;
        disc_n = 1'b1;
        @(negedge clk);
        check("wr_trdy_end", 1'b1, bus_i.trdyn);
        check("wr_stop_kept", 1'b0, bus_i.stopn);
        wait_idle();
        check("wr_count", 32'h1, n_words);
    endtask

    // first phase ends without data: by request or by the watchdog
    task automatic t_retry(input logic by_request);
        int k;
        rd_in = 32'h0000_5a5a;
        go(1'b0, 32'h0);
        disc_n = !by_request;
        wait_stop(k);
        if (by_request) check("retry_req_time", 32'h1, 32'(k < 6));
        else check("retry_time", 32'h1, 32'(k >= 12 && k <= 18));
        wait_idle();
        check("retry_trdy", 32'h0, n_trdy);
        check("retry_words", 32'h0, n_words);
    endtask

    // later phase ends without data: by request or by the watchdog
    task automatic t_no_data(input logic by_timer);
        int k;
        rd_in = 32'h1e2d_3c4b;
        go(1'b0, 32'h0);
        rdy_n = 1'b0;
        @(negedge clk);
        rdy_n = 1'b1;
        disc_n = by_timer;
        wait_stop(k);
        if (by_timer) check("nd_time", 32'h1, 32'(k >= 8 && k <= 12));
        wait_idle();
        check("nd_words", 32'h1, n_words);
        check("nd_trdy", 32'h1, n_trdy);
        check("nd_word", rd_in, rdata);
    endtask

    task automatic t_abort();
        int k;
        go(1'b0, 32'h0);
        abort_n = 1'b0;
        rdy_n = 1'b0;
        disc_n = 1'b0;
        wait_stop(k);
        @(negedge clk);
        check("ab_flag", 1'b1, abort_flag);
        wait_idle();
        check("ab_trdy", 32'h0, n_trdy);
        check("ab_words", 32'h0, n_words);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rstn = 1'b0;
        rdy_n = 1'b1;
        disc_n = 1'b1;
        abort_n = 1'b1;
        start = 1'b0;
        start_write = 1'b0;
        wdata = 32'h0;
        rd_in = 32'h0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        t_read_with_data();
        t_write_with_data();
        t_retry(1'b1);
        t_retry(1'b0);
        t_no_data(1'b0);
        t_no_data(1'b1);
        t_abort();
        t_read_with_data();
        report_and_stop();
    end

    // cut a hang short well past the expected run
    initial begin
        #(8 * 4000);
        n_mismatch = n_mismatch + 1;
        report_and_stop();
    end
endmodule
